// ===== shared/scs_map.svh
// address map, field positions, reset values and timing figures
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
// ----------------------------------------------------------------
// clock rate
// ----------------------------------------------------------------
`define SCS_CLK_MHZ        100
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCS_OFF_CTRL       8'h00
`define SCS_OFF_STAT       8'h04
`define SCS_OFF_MASK       8'h08
`define SCS_OFF_STATE      8'h0C
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SCS_CTRL_W         5
`define SCS_CTRL_QCGO      5
`define SCS_CTRL_RST       5'h06
// ----------------------------------------------------------------
// event bits of status and mask
// ----------------------------------------------------------------
`define SCS_EV_W           3
`define SCS_EV_CMFAIL      0
`define SCS_EV_QCPASS      1
`define SCS_EV_QCFAIL      2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCS_CM_TIMEOUT_NS  2000
`define SCS_QC_WINDOW_NS   40000
`define SCS_QC_EDGES       256
`define SCS_SELF_DIV       4
`define SCS_NUM_CAN        2
// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SCS_RESP_OKAY      2'h0
`define SCS_RESP_SLVERR    2'h2
`endif

// ===== shared/scs_pkg.sv
// types shared by the clock supervision design
`include "scs_map.svh"
package scs_pkg;
  // one-cycle clock enables handed to the consumers
  typedef struct packed {
    logic                        core;
    logic                        bus;
    logic                        flash_bus;
    logic                        flash_osc;
    logic                        lcd;
    logic [`SCS_NUM_CAN-1:0]     can;
  } scs_clk_en_t;
  // control register image, bit 0 at the bottom
  typedef struct packed {
    logic [`SCS_NUM_CAN-1:0]     can_osc;
    logic                        scme;
    logic                        cme;
    logic                        pll_sel;
  } scs_ctrl_t;
  // quality checker states
  typedef enum logic [1:0] {
    SCS_QC_IDLE = 2'b01,
    SCS_QC_RUN  = 2'b10
  } scs_qc_st_t;
endpackage

// ===== verilog/scs_edge.sv
// rising edge detector turning a sampled clock level into a tick
`timescale 1ns/100ps
`default_nettype none
module scs_edge (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // sampled level and its edge pulse
  input  wire logic lvl,
  output logic      tick
);
  logic prev;  // level one cycle ago

  // edge pulse is registered so consumers see a clean enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      prev <= lvl;
      tick <= lvl & ~prev;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/scs_qchk.sv
// clock quality checker: counts oscillator edges in a fixed window
`timescale 1ns/100ps
`default_nettype none
`include "scs_map.svh"
module scs_qchk
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // oscillator tick and launch request
  input  wire logic osc_tick,
  input  wire logic start,
  // result
  output logic      busy,
  output logic      done,
  output logic      pass
);
  localparam int WIN_CYC = `SCS_QC_WINDOW_NS * `SCS_CLK_MHZ / 1000;
  scs_qc_st_t  st;        // checker state
  logic [11:0] win_cnt;   // cycles spent in the window
  logic [8:0]  edges;     // edges seen, saturates at target
  wire         win_end = (win_cnt == 12'(WIN_CYC - 1));
  wire         reached = (edges == 9'(`SCS_QC_EDGES));

  assign busy = (st == SCS_QC_RUN);

  // launch is ignored while a window is open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= SCS_QC_IDLE;
      win_cnt <= 12'h000;
      edges   <= 9'h000;
      done    <= 1'b0;
      pass    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        SCS_QC_IDLE: begin
          win_cnt <= 12'h000;
          edges   <= 9'h000;
          if (start) st <= SCS_QC_RUN;
        end
        SCS_QC_RUN: begin
          win_cnt <= win_cnt + 12'h001;
          if (osc_tick && !reached) edges <= edges + 9'h001;
          if (win_end) begin
            st   <= SCS_QC_IDLE;
            done <= 1'b1;
            pass <= reached;
          end
        end
      endcase
    end
  end

  // window counter advances from zero over the first eight cycles after launch
  qc_window_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy) |-> (busy && !done) [*8] ##0 (win_cnt == 12'h007))
    else $error("quality window counter not advancing");
  qc_verdict_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy && win_end) |=> done && !busy && (pass == $past(reached)))
    else $error("quality verdict wrong or late");
endmodule
`default_nettype wire

// ===== verilog/scs_top.sv
// clock selection, distribution enables, clock monitor and AXI regs
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "scs_map.svh"
module scs_top
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // axi4-lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // axi4-lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // sampled clock sources and wake event
  input  wire logic        osc_in,
  input  wire logic        pll_in,
  input  wire logic        wakeup,
  // clock enables, reset request and interrupt
  output scs_clk_en_t      clk_en,
  output logic             sys_reset_req,
  output logic             irq
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int CM_CYC = `SCS_CM_TIMEOUT_NS * `SCS_CLK_MHZ / 1000;

  // one-hot decode of a register offset, all zero when unmapped
  function automatic logic [3:0] scs_dec(input logic [7:0] a);
    scs_dec = {a == `SCS_OFF_STATE, a == `SCS_OFF_MASK,
               a == `SCS_OFF_STAT,  a == `SCS_OFF_CTRL};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  scs_ctrl_t             ctrl;       // software control image
  logic [`SCS_EV_W-1:0]  status;     // sticky events
  logic [`SCS_EV_W-1:0]  mask;       // interrupt enables
  logic                  qc_go;      // software launch pulse
  logic                  osc_tick;   // oscillator rising edge
  logic                  pll_tick;   // pll rising edge
  logic [1:0]            self_cnt;   // self-clock divider
  logic                  self_tick;  // self-clock enable
  logic                  self_clk;   // running on self-clock
  logic                  bus_ph;     // bus divide-by-two phase
  logic [7:0]            cm_cnt;     // cycles since last osc edge
  logic                  osc_lost;   // monitor has timed out
  logic                  qc_busy;    // quality window open
  logic                  qc_done;    // quality verdict pulse
  logic                  qc_pass;    // last verdict
  logic                  aw_got;     // write address held
  logic                  w_got;      // write data held
  logic [7:0]            aw_addr;    // held write address
  logic [31:0]           w_data;     // held write data
  logic [3:0]            w_strb;     // held write strobes
  scs_clk_en_t           next_clk;   // enables before the register

  // ----------------------------------------------------------------
  // source edge detection and quality checker
  // ----------------------------------------------------------------
  scs_edge u_osc_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lvl     (osc_in),
    .tick    (osc_tick)
  );

  scs_edge u_pll_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lvl     (pll_in),
    .tick    (pll_tick)
  );

  // monitor has gone a full timeout without an oscillator edge
  wire cm_hit = (cm_cnt == 8'(CM_CYC - 1));
  // wake-up, monitor failure or software can open a window
  wire cm_fail = cm_hit & ctrl.cme & ~osc_lost;
  wire qc_start = wakeup | cm_fail | qc_go;

  scs_qchk u_qchk (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .osc_tick (osc_tick),
    .start    (qc_start),
    .busy     (qc_busy),
    .done     (qc_done),
    .pass     (qc_pass)
  );

  // ----------------------------------------------------------------
  // clock monitor
  // ----------------------------------------------------------------
  // counter restarts on every oscillator edge and saturates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cm_cnt   <= 8'h00;
      osc_lost <= 1'b0;
    end else if (osc_tick) begin
      cm_cnt   <= 8'h00;
      osc_lost <= 1'b0;
    end else if (cm_hit) begin
      osc_lost <= osc_lost | ctrl.cme;
    end else begin
      cm_cnt   <= cm_cnt + 8'h01;
    end
  end

  // failure falls back to self-clock or asks for a system reset;
  // self-clock is left only once a quality window passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      self_clk      <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= cm_fail & ~ctrl.scme;
      if (cm_fail && ctrl.scme) begin
        self_clk <= 1'b1;
      end else if (qc_done && qc_pass) begin
        self_clk <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // self-clock divider
  // ----------------------------------------------------------------
  wire self_wrap = (self_cnt == 2'(`SCS_SELF_DIV - 1));

  // free-running stand-in for the pll in self-clock mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      self_cnt  <= 2'h0;
      self_tick <= 1'b0;
    end else begin
      self_cnt  <= self_wrap ? 2'h0 : self_cnt + 2'h1;
      self_tick <= self_wrap;
    end
  end

  // ----------------------------------------------------------------
  // clock selection and distribution
  // ----------------------------------------------------------------
  // self-clock overrides the software choice
  wire src_tick = self_clk     ? self_tick :
                  ctrl.pll_sel ? pll_tick  : osc_tick;

  always_comb begin
    next_clk           = '0;
    next_clk.core      = src_tick;
    next_clk.bus       = src_tick & bus_ph;
    next_clk.flash_bus = src_tick & bus_ph;
    next_clk.flash_osc = osc_tick;
    next_clk.lcd       = osc_tick;
    for (int i = 0; i < `SCS_NUM_CAN; i++) begin
      next_clk.can[i] = ctrl.can_osc[i] ? osc_tick
                                        : (src_tick & bus_ph);
    end
  end

  // bus runs at half the core rate; enables are registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_ph <= 1'b0;
      clk_en <= '0;
    end else begin
      if (src_tick) bus_ph <= ~bus_ph;
      clk_en <= next_clk;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  // address and data may arrive in either order; both are held
  // and the write is applied one cycle after the later one
  assign awready = ~aw_got & ~bvalid;
  assign wready  = ~w_got & ~bvalid;
  wire   do_wr   = aw_got & w_got;
  wire   [3:0] wr_hit = scs_dec(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (do_wr) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // response; unmapped or read-only targets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SCS_RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= (wr_hit[0] | wr_hit[2]) ? `SCS_RESP_OKAY
                                        : `SCS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // control and mask live in byte lane 0
  wire wr_lane0 = do_wr & w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl  <= scs_ctrl_t'(`SCS_CTRL_RST);
      mask  <= '0;
      qc_go <= 1'b0;
    end else begin
      qc_go <= wr_lane0 & wr_hit[0] & w_data[`SCS_CTRL_QCGO];
      if (wr_lane0 && wr_hit[0]) ctrl <= w_data[`SCS_CTRL_W-1:0];
      if (wr_lane0 && wr_hit[2]) mask <= w_data[`SCS_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path and event status
  // ----------------------------------------------------------------
  assign arready = ~rvalid;
  wire   rd_take = arvalid & arready;
  wire   [3:0] rd_hit = scs_dec(araddr);
  wire   [31:0] rd_word =
    rd_hit[0] ? 32'(ctrl) :
    rd_hit[1] ? 32'(status) :
    rd_hit[2] ? 32'(mask) :
    rd_hit[3] ? {28'h0, qc_pass, qc_busy, osc_lost, self_clk} :
                32'h0000_0000;

  // events of this cycle; a new event beats a read-clear
  wire [`SCS_EV_W-1:0] ev = {qc_done & ~qc_pass, qc_done & qc_pass,
                             cm_fail};
  wire [`SCS_EV_W-1:0] rd_clr = {`SCS_EV_W{rd_take & rd_hit[1]}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~rd_clr) | ev;
    end
  end

  // read data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `SCS_RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= (|rd_hit) ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking scs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_cm_timeout;
    !osc_tick && cm_hit && ctrl.cme && !osc_lost;
  endsequence

  src_select_a: assert property (
    (!self_clk && ctrl.pll_sel) |=> (clk_en.core == $past(pll_tick)))
    else $error("core enable not following pll");
  bus_half_a: assert property (
    clk_en.bus |-> clk_en.core && !$past(clk_en.bus, 2))
    else $error("bus enable faster than half core");
  flash_base_a: assert property (
    osc_tick |=> clk_en.flash_osc && (clk_en.flash_bus == clk_en.bus))
    else $error("flash time base missing");
  can_osc_a: assert property (
    (ctrl.can_osc[0] && osc_tick) |=> clk_en.can[0])
    else $error("can clock not on oscillator");
  lcd_osc_a: assert property (
    (osc_tick && ctrl.pll_sel) |=> clk_en.lcd)
    else $error("lcd clock not from oscillator");
  cm_reset_a: assert property (
    (s_cm_timeout and !ctrl.scme) |=> sys_reset_req ##1 !sys_reset_req)
    else $error("monitor timeout without reset request");
  cm_self_a: assert property (
    (s_cm_timeout and ctrl.scme) |=> self_clk && qc_busy)
    else $error("monitor timeout without self-clock");
  qc_wake_a: assert property (
    (wakeup && !qc_busy) |=> qc_busy)
    else $error("wake-up did not launch quality check");
  qc_flag_a: assert property (
    qc_done |=> (status[`SCS_EV_QCPASS] == $past(qc_pass))
                && (status[`SCS_EV_QCFAIL] == !$past(qc_pass)))
    else $error("quality verdict not flagged");
endmodule
`default_nettype wire

// ===== bench/scs_src.sv
// oscillator and pll source model feeding the sampled clock inputs
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// source model
// ----------------------------------------------------------------
module scs_src (
  // clock
  input  wire logic       aclk,
  // oscillator run control and half periods in aclk cycles
  input  wire logic       osc_run,
  input  wire logic [7:0] osc_half,
  input  wire logic [7:0] pll_half,
  // sampled source levels
  output logic            osc_in,
  output logic            pll_in
);
  logic [7:0] osc_cnt;  // cycles since the last oscillator toggle
  logic [7:0] pll_cnt;  // cycles since the last pll toggle
  initial begin
    osc_in  = 1'b0;
    pll_in  = 1'b0;
    osc_cnt = 8'h00;
    pll_cnt = 8'h00;
  end
  // a dead crystal freezes its level, so the monitor sees no edges
  always @(posedge aclk) begin
    if (osc_run && osc_cnt + 8'h01 >= osc_half) begin
      osc_cnt <= 8'h00;
      osc_in  <= !osc_in;
    end else if (osc_run) begin
      osc_cnt <= osc_cnt + 8'h01;
    end
    // the pll keeps running, it is never the part that fails here
    if (pll_cnt + 8'h01 >= pll_half) begin
      pll_cnt <= 8'h00;
      pll_in  <= !pll_in;
    end else begin
      pll_cnt <= pll_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== bench/system_clock_supervision_tb.sv
// self-checking bench for the clock supervision block
`timescale 1ns/100ps
`default_nettype none
`include "scs_map.svh"
module system_clock_supervision_tb;
  import scs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, osc_half;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        osc_in, pll_in, wakeup, osc_run, sys_reset_req, irq;
  scs_clk_en_t clk_en;
  logic [33:0] exp_b[$];   // expected write responses, oldest first
  logic [33:0] exp_r[$];   // expected read {resp, data}, oldest first
  int          n_errors, checks, np;
  int          cnt[7];     // enable ticks seen per clk_en bit
  // ----------------------------------------------------------------
  // design and source model
  // ----------------------------------------------------------------
  scs_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .osc_in(osc_in), .pll_in(pll_in), .wakeup(wakeup), .clk_en(clk_en),
    .sys_reset_req(sys_reset_req), .irq(irq));
  scs_src src (.aclk(aclk), .osc_run(osc_run), .osc_half(osc_half),
    .pll_half(8'h02), .osc_in(osc_in), .pll_in(pll_in));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // handshakes are judged mid-cycle, where every signal is settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bit ad, dd, bd;
    exp_b.push_back({32'h0, er});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bd = 1'b0;
    while (!bd) begin
      @(negedge aclk);
      ad = awvalid && awready;
      dd = wvalid && wready;
      bd = bvalid && bready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
      if (bd) bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    bit ad, rd;
    exp_r.push_back(e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rd = 1'b0;
    while (!rd) begin
      @(negedge aclk);
      ad = arvalid && arready;
      rd = rvalid && rready;
      @(posedge aclk);
      if (ad) arvalid <= 1'b0;
      if (rd) rready <= 1'b0;
    end
  endtask
  // tally enables and reset pulses over n cycles
  task automatic count_run(input int n);
    np = 0;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (n) begin
      @(posedge aclk);
      foreach (cnt[i]) cnt[i] += int'(clk_en[i]);
      np += int'(sys_reset_req);
    end
  endtask
  // source phase is free, so each count may be two ticks off
  task automatic chk_cnt(input int e[7]);
    foreach (cnt[i]) check({33'h0, cnt[i] >= e[i] - 2 && cnt[i] <= e[i] + 2},
                           34'h1);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    check({33'h0, irq}, {33'h0, e});
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and response monitor
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = !aclk;
  end
  // the full run takes about 19100 cycles
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
  // every answer is compared against the oldest outstanding note
  always @(negedge aclk) begin
    if (bvalid && bready) check({32'h0, bresp}, exp_b.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wakeup} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    wstrb = 4'hF;
    osc_run = 1'b1;
    osc_half = 8'h03;
    n_errors = 0;
    checks = 0;
    rnd = 32'hBD1A;
    aresetn = 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    // reset values, refused writes and an unmapped read
    axi_rd(`SCS_OFF_CTRL, 34'h6);
    axi_rd(`SCS_OFF_MASK, 34'h0);
    axi_rd(`SCS_OFF_STAT, 34'h0);
    axi_rd(8'h10, {`SCS_RESP_SLVERR, 32'h0});
    axi_wr(`SCS_OFF_STAT, 32'h7, `SCS_RESP_SLVERR);
    axi_wr(8'h14, 32'h1, `SCS_RESP_SLVERR);
    // oscillator source, can1 on the oscillator; junk in unused bits
    rnd = lfsr(rnd);
    axi_wr(`SCS_OFF_CTRL, {rnd[31:6], 6'h16}, `SCS_RESP_OKAY);
    axi_rd(`SCS_OFF_CTRL, 34'h16);
    count_run(600);
    chk_cnt('{50, 100, 100, 100, 50, 50, 100});
    // pll source, can0 on the oscillator; lcd must not follow the pll
    axi_wr(`SCS_OFF_CTRL, 32'h0F, `SCS_RESP_OKAY);
    count_run(600);
    chk_cnt('{100, 75, 100, 100, 75, 75, 150});
    // software launched check with a fast oscillator passes
    axi_wr(`SCS_OFF_CTRL, 32'h26, `SCS_RESP_OKAY);
    axi_rd(`SCS_OFF_CTRL, 34'h6);
    cyc(4100);
    chk_irq(1'b0);
    axi_wr(`SCS_OFF_MASK, 32'h7, `SCS_RESP_OKAY);
    chk_irq(1'b1);
    axi_rd(`SCS_OFF_STAT, 34'h2);
    chk_irq(1'b0);
    // wake-up launches a check; 200 edges in the window is too few
    @(posedge aclk) osc_half <= 8'h0A;
    cyc(20);
    @(posedge aclk) wakeup <= 1'b1;
    @(posedge aclk) wakeup <= 1'b0;
    // window open, and the earlier passing verdict is still held
    axi_rd(`SCS_OFF_STATE, 34'hC);
    cyc(4100);
    axi_rd(`SCS_OFF_STAT, 34'h4);
    // oscillator dies with self-clocking allowed
    @(posedge aclk) osc_half <= 8'h03;
    @(posedge aclk) osc_run <= 1'b0;
    cyc(300);
    axi_rd(`SCS_OFF_STATE, 34'h7);
    count_run(400);
    chk_cnt('{50, 50, 0, 0, 50, 50, 100});
    chk_irq(1'b1);
    axi_rd(`SCS_OFF_STAT, 34'h1);
    cyc(4000);
    axi_rd(`SCS_OFF_STAT, 34'h4);
    // oscillator back, a passing check leaves self-clocking
    @(posedge aclk) osc_run <= 1'b1;
    cyc(20);
    axi_wr(`SCS_OFF_CTRL, 32'h26, `SCS_RESP_OKAY);
    cyc(4100);
    axi_rd(`SCS_OFF_STATE, 34'h8);
    axi_rd(`SCS_OFF_STAT, 34'h2);
    // monitor off: a dead oscillator raises nothing
    axi_wr(`SCS_OFF_CTRL, 32'h0, `SCS_RESP_OKAY);
    @(posedge aclk) osc_run <= 1'b0;
    count_run(400);
    check(34'(np), 34'h0);
    axi_rd(`SCS_OFF_STAT, 34'h0);
    // monitor on without self-clocking: exactly one reset request
    @(posedge aclk) osc_run <= 1'b1;
    cyc(20);
    axi_wr(`SCS_OFF_CTRL, 32'h2, `SCS_RESP_OKAY);
    @(posedge aclk) osc_run <= 1'b0;
    count_run(400);
    check(34'(np), 34'h1);
    axi_rd(`SCS_OFF_STAT, 34'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
